// *** logic/module_monitor_cfg.svh ***
// register offsets, id codes and timing counts of the power module link monitor
`ifndef MODULE_MONITOR_CFG_SVH
`define MODULE_MONITOR_CFG_SVH
`define MM_ADDR_W 8
`define MM_OFF_LINK 8'h00
`define MM_OFF_DATA 8'h04
`define MM_OFF_EXPECT 8'h08
`define MM_OFF_CTRL 8'h0c
`define MM_OFF_FAULT 8'h10
`define MM_OFF_IRQ_STAT 8'h14
`define MM_OFF_IRQ_MASK 8'h18
`define MM_OFF_MODE 8'h1c
`define MM_OFF_FUSE 8'h20
`define MM_OFF_HEAT 8'h24
`define MM_OFF_MISM 8'h28
`define MM_OFF_SEVER 8'h2c
`define MM_OFF_ID_BASE 8'h40
`define MM_ID_UNDETECTED 16'hffff
`define MM_FAULT_TIMEOUT_ID 16'h13e2
`define MM_FAULT_MISMATCH_ID 16'h13df
`define MM_BLINK_NS 250000000
`define MM_CLK_NS 10
`define MM_BLINK_CYC (`MM_BLINK_NS / `MM_CLK_NS)
`define MM_TIMEOUT_NS 100000000
`define MM_TIMEOUT_CYC (`MM_TIMEOUT_NS / `MM_CLK_NS)
`define MM_DC_LOW_LIMIT 16'h0032
// fault summary bit positions
`define MM_FB_TIMEOUT 0
`define MM_FB_MISMATCH 1
`define MM_FB_FUSE 2
`define MM_FB_HEAT 3
`define MM_FB_LINK 4
`define MM_FB_DATA 5
`endif

// *** logic/module_monitor_pkg.sv ***
// types shared by the power module link monitor
package module_monitor_pkg;
  typedef enum logic [1:0] {
    sev_fault,
    sev_warning,
    sev_disabled
  } severity_t;
  typedef enum logic {
    mode_normal,
    mode_led_test
  } run_mode_t;
endpackage

// *** logic/module_monitor.sv ***
// supervises up to eight paralleled power modules: link, size code, fuse and heatsink faults
`timescale 1ns/1ps
`default_nettype none
`include "module_monitor_cfg.svh"
module module_monitor #(
  parameter int unsigned NUM_MODULES = 8,
  parameter int unsigned TIMEOUT_CYC = `MM_TIMEOUT_CYC,
  parameter int unsigned BLINK_CYC = `MM_BLINK_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [`MM_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // module link side (asynchronous pins)
  input wire logic [NUM_MODULES-1:0] link_up_i,
  input wire logic [NUM_MODULES-1:0] data_err_i,
  input wire logic [NUM_MODULES-1:0] fuse_open_i,
  input wire logic [NUM_MODULES-1:0] heat_trip_i,
  input wire logic [NUM_MODULES-1:0] id_valid_i,
  input wire logic [NUM_MODULES*10-1:0] size_switch_bank_i,
  // drive side
  input wire logic switch_on_command_bit_i,
  input wire logic fault_ack_i,
  input wire logic [15:0] dc_bus_volts_i,
  input wire logic [7:0] fieldbus_family_i,
  // outputs
  output logic [NUM_MODULES-1:0] led_green_o,
  output logic [NUM_MODULES-1:0] led_yellow_o,
  output logic [NUM_MODULES-1:0] led_red_o,
  output logic fieldbus_src_ok_o,
  output logic fault_o,
  output logic warn_o,
  output logic [15:0] fault_id_o,
  output logic irq_o
);
  localparam int unsigned NM = NUM_MODULES;

  // decoded id entry offset: returns index or NM when outside the entries
  function automatic logic [3:0] id_index(input logic [`MM_ADDR_W-1:0] a);
    logic [`MM_ADDR_W-1:0] d;
    d = a - `MM_OFF_ID_BASE;
    if (a >= `MM_OFF_ID_BASE && d[1:0] == 2'b00 && d[`MM_ADDR_W-1:2] < NM)
      id_index = d[5:2];
    else
      id_index = 4'(NM);
  endfunction

  // --- input synchronisers, two stages each
  localparam int unsigned SW = 5 * NM + NM * 10 + 2;
  logic [SW-1:0] sync1_ff, sync2_ff;
  wire logic [SW-1:0] raw_in = {link_up_i, data_err_i, fuse_open_i, heat_trip_i, id_valid_i,
                                size_switch_bank_i, switch_on_command_bit_i, fault_ack_i};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (ce_i) begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end
  logic [NM-1:0] link_s, derr_s, fuse_s, heat_s, idv_s;
  logic [NM*10-1:0] sw_s;
  logic son_s, ack_s;
  assign {link_s, derr_s, fuse_s, heat_s, idv_s, sw_s, son_s, ack_s} = sync2_ff;

  // --- registers written by software
  logic [NM-1:0] enable_ff;
  logic [9:0] expect_code_ff;
  logic [5:0] expect_fw_ff;
  logic [5:0] irq_mask_ff;
  logic test_req_ff;
  logic [1:0] sev_mismatch_ff, sev_timeout_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable_ff <= '0;
      expect_code_ff <= '0;
      expect_fw_ff <= '0;
      irq_mask_ff <= '0;
      test_req_ff <= 1'b0;
      sev_mismatch_ff <= 2'h0;
      sev_timeout_ff <= 2'h0;
    end else if (ce_i && wr_i) begin
      if (addr_i == `MM_OFF_CTRL)
        enable_ff <= wdata_i[NM-1:0];
      if (addr_i == `MM_OFF_EXPECT) begin
        expect_code_ff <= wdata_i[15:6];
        expect_fw_ff <= wdata_i[5:0];
      end
      if (addr_i == `MM_OFF_IRQ_MASK)
        irq_mask_ff <= wdata_i[5:0];
      if (addr_i == `MM_OFF_MODE)
        test_req_ff <= wdata_i[0];
      if (addr_i == `MM_OFF_SEVER) begin
        sev_timeout_ff <= wdata_i[1:0];
        sev_mismatch_ff <= wdata_i[3:2];
      end
    end
  end

  // --- status words and id decoding
  logic [NM-1:0] link_lost_ff, data_bad_ff;
  logic [15:0] id_code_ff [NM];
  logic [NM-1:0] mism_now;
  genvar g;
  generate
    for (g = 0; g < NM; g++) begin : g_mod
      wire logic [9:0] sw = sw_s[g*10 +: 10];
      wire logic [15:0] code = {6'h00, sw};
      assign mism_now[g] = enable_ff[g] && link_s[g] && idv_s[g] && sw != expect_code_ff;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          id_code_ff[g] <= 16'h0000;
        end else if (ce_i) begin
          if (!enable_ff[g] || !link_s[g])
            id_code_ff[g] <= 16'h0000;
          else if (!idv_s[g])
            id_code_ff[g] <= `MM_ID_UNDETECTED;
          else
            id_code_ff[g] <= code;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      link_lost_ff <= '0;
      data_bad_ff <= '0;
    end else if (ce_i) begin
      link_lost_ff <= enable_ff & ~link_s;
      data_bad_ff <= enable_ff & link_s & derr_s;
    end
  end

  // --- config timeout counter
  logic [31:0] tmo_cnt_ff;
  wire logic tmo_now = tmo_cnt_ff >= TIMEOUT_CYC;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      tmo_cnt_ff <= '0;
    else if (ce_i) begin
      if ((enable_ff & ~link_s) == '0)
        tmo_cnt_ff <= '0;
      else if (!tmo_now)
        tmo_cnt_ff <= tmo_cnt_ff + 32'h0000_0001;
    end
  end

  // --- latched faults
  logic ack_d_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      ack_d_ff <= 1'b0;
    else if (ce_i)
      ack_d_ff <= ack_s;
  end
  wire logic ack_rise = ack_s && !ack_d_ff;
  logic [NM-1:0] fuse_flt_ff, heat_flt_ff, mism_flt_ff;
  logic tmo_flt_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fuse_flt_ff <= '0;
      heat_flt_ff <= '0;
      mism_flt_ff <= '0;
      tmo_flt_ff <= 1'b0;
    end else if (ce_i) begin
      fuse_flt_ff <= (enable_ff & fuse_s) | (ack_rise ? '0 : fuse_flt_ff);
      heat_flt_ff <= (enable_ff & heat_s) | (ack_rise ? '0 : heat_flt_ff);
      mism_flt_ff <= mism_now | (ack_rise ? '0 : mism_flt_ff);
      tmo_flt_ff <= tmo_now | (ack_rise ? 1'b0 : tmo_flt_ff);
    end
  end

  wire logic hw_alarm = |fuse_flt_ff || |heat_flt_ff;
  wire logic tmo_is_flt = tmo_flt_ff && sev_timeout_ff == 2'(module_monitor_pkg::sev_fault);
  wire logic mis_is_flt = |mism_flt_ff && sev_mismatch_ff == 2'(module_monitor_pkg::sev_fault);
  wire logic tmo_is_wrn = tmo_flt_ff && sev_timeout_ff == 2'(module_monitor_pkg::sev_warning);
  wire logic mis_is_wrn = |mism_flt_ff && sev_mismatch_ff == 2'(module_monitor_pkg::sev_warning);
  wire logic any_fault = hw_alarm || tmo_is_flt || mis_is_flt;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_o <= 1'b0;
      warn_o <= 1'b0;
      fault_id_o <= 16'h0000;
    end else if (ce_i) begin
      fault_o <= any_fault;
      warn_o <= tmo_is_wrn || mis_is_wrn;
      if (tmo_is_flt)
        fault_id_o <= `MM_FAULT_TIMEOUT_ID;
      else if (mis_is_flt)
        fault_id_o <= `MM_FAULT_MISMATCH_ID;
      else
        fault_id_o <= 16'h0000;
    end
  end

  // --- led test mode
  module_monitor_pkg::run_mode_t mode_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      mode_ff <= module_monitor_pkg::mode_normal;
    else if (ce_i) begin
      unique case (mode_ff)
        module_monitor_pkg::mode_normal: begin
          if (test_req_ff && !son_s && !any_fault && dc_bus_volts_i < `MM_DC_LOW_LIMIT)
            mode_ff <= module_monitor_pkg::mode_led_test;
        end
        module_monitor_pkg::mode_led_test: begin
          if (!test_req_ff || any_fault)
            mode_ff <= module_monitor_pkg::mode_normal;
        end
      endcase
    end
  end
  wire logic in_test = mode_ff == module_monitor_pkg::mode_led_test;

  logic [31:0] blink_cnt_ff;
  logic blink_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
    end else if (ce_i) begin
      if (blink_cnt_ff >= BLINK_CYC - 1) begin
        blink_cnt_ff <= '0;
        blink_ff <= !blink_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
      end
    end
  end

  generate
    for (g = 0; g < NM; g++) begin : g_led
      localparam logic [2:0] PAT = (g < 5) ? 3'(g + 1) : 3'(g - 4);
      localparam bit BLINKS = g >= 5;
      wire logic on = in_test && (!BLINKS || blink_ff);
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          led_green_o[g] <= 1'b0;
          led_yellow_o[g] <= 1'b0;
          led_red_o[g] <= 1'b0;
        end else if (ce_i) begin
          led_green_o[g] <= on && PAT[0];
          led_yellow_o[g] <= on && PAT[1];
          led_red_o[g] <= on && PAT[2];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      fieldbus_src_ok_o <= 1'b0;
    else if (ce_i)
      fieldbus_src_ok_o <= fieldbus_family_i >= 8'h3c && fieldbus_family_i <= 8'h4a;
  end

  // --- interrupt status, set wins over write-one clear
  logic [5:0] irq_stat_ff;
  wire logic [5:0] irq_ev = {|data_bad_ff, |link_lost_ff, |heat_flt_ff, |fuse_flt_ff,
                             |mism_flt_ff, tmo_flt_ff};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      irq_stat_ff <= '0;
    else if (ce_i) begin
      if (wr_i && addr_i == `MM_OFF_IRQ_STAT)
        irq_stat_ff <= (irq_stat_ff & ~wdata_i[5:0]) | irq_ev;
      else
        irq_stat_ff <= irq_stat_ff | irq_ev;
    end
  end
  // hardware alarm bits bypass the mask so they cannot be hidden
  assign irq_o = |(irq_stat_ff & irq_mask_ff) || irq_stat_ff[`MM_FB_FUSE]
                 || irq_stat_ff[`MM_FB_HEAT];

  // --- read port
  logic [3:0] idx;
  always_comb begin
    idx = id_index(addr_i);
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (ce_i) begin
      rdata_o <= '0;
      if (rd_i) begin
        if (idx < NM)
          rdata_o <= {16'h0000, id_code_ff[idx[2:0]]};
        else
          unique case (addr_i)
            `MM_OFF_LINK: rdata_o <= 32'(link_lost_ff);
            `MM_OFF_DATA: rdata_o <= 32'(data_bad_ff);
            `MM_OFF_EXPECT: rdata_o <= {16'h0000, expect_code_ff, expect_fw_ff};
            `MM_OFF_CTRL: rdata_o <= 32'(enable_ff);
            `MM_OFF_FAULT: rdata_o <= {26'h0, |data_bad_ff, |link_lost_ff, |heat_flt_ff,
                                       |fuse_flt_ff, |mism_flt_ff, tmo_flt_ff};
            `MM_OFF_IRQ_STAT: rdata_o <= {26'h0, irq_stat_ff};
            `MM_OFF_IRQ_MASK: rdata_o <= {26'h0, irq_mask_ff};
            `MM_OFF_MODE: rdata_o <= {30'h0, in_test, test_req_ff};
            `MM_OFF_FUSE: rdata_o <= 32'(fuse_flt_ff);
            `MM_OFF_HEAT: rdata_o <= 32'(heat_flt_ff);
            `MM_OFF_MISM: rdata_o <= 32'(mism_flt_ff);
            `MM_OFF_SEVER: rdata_o <= {28'h0, sev_mismatch_ff, sev_timeout_ff};
            default: rdata_o <= '0;
          endcase
      end
    end
  end

  // --- assertions
  fault_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && $rose(tmo_flt_ff) && !ack_rise |=> tmo_flt_ff)
    else $error("timeout fault dropped without acknowledge");
  fuse_report_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && (enable_ff & fuse_s) != '0 |=> fault_o || !ce_i || $past(fuse_flt_ff) == '0)
    else $error("fuse fault not reported");
  test_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(in_test) |-> $past(!son_s && !any_fault && dc_bus_volts_i < `MM_DC_LOW_LIMIT))
    else $error("test mode entered under wrong conditions");
  led_blank_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !in_test |=> led_green_o == '0 && led_yellow_o == '0 && led_red_o == '0)
    else $error("leds lit outside test mode");
  link_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> link_lost_ff == $past(enable_ff & ~link_s))
    else $error("link status word wrong");
  timeout_id_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && tmo_is_flt |=> fault_id_o == `MM_FAULT_TIMEOUT_ID)
    else $error("timeout id wrong");
  hw_unmasked_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_stat_ff[`MM_FB_FUSE] |-> irq_o)
    else $error("hardware alarm masked");
  fieldbus_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && fieldbus_family_i == 8'h4b |=> !fieldbus_src_ok_o)
    else $error("family 75 exported");
endmodule
`default_nettype wire

// *** tb/power_module_model.sv ***
// behavioural model of up to eight paralleled power modules on their link pairs
`timescale 1ns/1ps
`default_nettype none
module power_module_model (
  // clock
  input wire logic clk_i,
  // link pins toward the monitor
  output logic [7:0] link_up_o,
  output logic [7:0] data_err_o,
  output logic [7:0] fuse_open_o,
  output logic [7:0] heat_trip_o,
  output logic [7:0] id_valid_o,
  output logic [79:0] size_switch_bank_o
);
  logic [7:0] plug = 8'hff;
  logic [7:0] err = 8'h00;
  logic [7:0] fuse = 8'h00;
  logic [7:0] heat = 8'h00;
  logic [7:0] det = 8'hff;
  logic [9:0] code [8];
  logic flip = 1'b0;
  initial begin
    for (int i = 0; i < 8; i++) begin
      code[i] = 10'h005;
    end
  end
  always @(posedge clk_i) begin
    flip <= ~flip;
  end
  task automatic put(input int n, input logic p, input logic e, input logic f, input logic h,
      input logic d, input logic [9:0] c);
    plug[n] = p;
    err[n] = e;
    fuse[n] = f;
    heat[n] = h;
    det[n] = d;
    code[n] = c;
  endtask
  assign link_up_o = plug;
  assign data_err_o = err & plug;
  assign fuse_open_o = fuse & plug;
  assign heat_trip_o = heat & plug;
  assign id_valid_o = det & plug;
  for (genvar i = 0; i < 8; i++) begin : g_sw
    // an unplugged or undetected module shows churning switches, its code inverted on every other clock
    assign size_switch_bank_o[i*10+:10] = (plug[i] && det[i]) ? code[i] : code[i] ^ {10{flip}};
  end
endmodule
`default_nettype wire

// *** tb/power_module_link_monitor_tb.sv ***
// self-checking bench of the power module link monitor
`timescale 1ns/1ps
`default_nettype none
module power_module_link_monitor_tb;
  localparam int unsigned TMO = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdata_o;
  logic [7:0] link_up, data_err, fuse_open, heat_trip, id_valid, led_g, led_y, led_r;
  logic [79:0] bank;
  logic sw_on = 1'b0;
  logic ack = 1'b0;
  logic [15:0] dc_volts = 16'h0000;
  logic [7:0] family = 8'h00;
  logic src_ok, fault_o, warn_o, irq_o;
  logic [15:0] fault_id;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  power_module_model power_module_model_inst (.clk_i(clk_i), .link_up_o(link_up),
    .data_err_o(data_err), .fuse_open_o(fuse_open), .heat_trip_o(heat_trip),
    .id_valid_o(id_valid), .size_switch_bank_o(bank));
  module_monitor #(.NUM_MODULES(8), .TIMEOUT_CYC(TMO), .BLINK_CYC(4)) module_monitor_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_up_i(link_up), .data_err_i(data_err),
    .fuse_open_i(fuse_open), .heat_trip_i(heat_trip), .id_valid_i(id_valid),
    .size_switch_bank_i(bank), .switch_on_command_bit_i(sw_on), .fault_ack_i(ack),
    .dc_bus_volts_i(dc_volts), .fieldbus_family_i(family), .led_green_o(led_g),
    .led_yellow_o(led_y), .led_red_o(led_r), .fieldbus_src_ok_o(src_ok), .fault_o(fault_o),
    .warn_o(warn_o), .fault_id_o(fault_id), .irq_o(irq_o));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang costs a mismatch instead of running forever
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, rdata_o, exp);
  endtask
  task automatic mod(input int n, input logic p, input logic e, input logic f, input logic h,
      input logic d, input logic [9:0] c);
    power_module_model_inst.put(n, p, e, f, h, d, c);
  endtask
  // ack is resynchronised, so it is held well past the two sync stages
  task automatic pulse_ack;
    ack <= 1'b1;
    cyc(4);
    ack <= 1'b0;
    cyc(4);
  endtask
  task automatic t_reset;
    chk("fault after reset", {fault_o, irq_o, fault_id}, 32'h0);
    rdchk("link word", 8'h00, 32'h0);
    rdchk("fault summary", 8'h10, 32'h0);
  endtask
  task automatic t_regs;
    wr(8'h0c, 32'hff);
    rdchk("enable", 8'h0c, 32'hff);
    // a write while the enable is low must leave every register untouched
    ce <= 1'b0;
    wr(8'h0c, 32'h0);
    ce <= 1'b1;
    rdchk("frozen enable", 8'h0c, 32'hff);
    wr(8'h08, 32'h0143);
    rdchk("expected size", 8'h08, 32'h0143);
    wr(8'h30, 32'hffffffff);
    rdchk("unmapped", 8'h30, 32'h0);
  endtask
  task automatic t_link;
    mod(1, 0, 0, 0, 0, 1, 10'h005);
    cyc(4);
    rdchk("link word", 8'h00, 32'h02);
    rdchk("data word", 8'h04, 32'h00);
    cyc(TMO);
    chk("timeout id", {fault_o, fault_id}, {1'b1, 16'h13e2});
    pulse_ack;
    chk("fault held", fault_o, 1'b1);
    mod(1, 1, 0, 0, 0, 1, 10'h005);
    cyc(4);
    chk("fault latched", fault_o, 1'b1);
    pulse_ack;
    chk("fault cleared", {fault_o, fault_id}, 32'h0);
    mod(0, 1, 1, 0, 0, 1, 10'h005);
    cyc(4);
    rdchk("data word", 8'h04, 32'h01);
    mod(0, 1, 0, 0, 0, 1, 10'h005);
    wr(8'h2c, 32'h1);
    mod(7, 0, 0, 0, 0, 1, 10'h005);
    cyc(TMO + 4);
    chk("timeout warning", warn_o, 1'b1);
    mod(7, 1, 0, 0, 0, 1, 10'h005);
    wr(8'h2c, 32'h0);
    pulse_ack;
    wr(8'h14, 32'hffffffff);
  endtask
  task automatic t_size;
    wr(8'h08, 32'h8043);
    for (int i = 0; i < 8; i++) mod(i, 1, 0, 0, 0, 1, 10'h201);
    cyc(4);
    pulse_ack;
    chk("size match", {fault_o, fault_id}, 32'h0);
    for (int i = 0; i < 8; i++) rdchk("id code", 8'h40 + 8'(4 * i), 32'h201);
    mod(4, 1, 0, 0, 0, 1, 10'h203);
    cyc(4);
    chk("mismatch id", fault_id, 16'h13df);
    rdchk("mismatch word", 8'h28, 32'h10);
    rdchk("id code", 8'h50, 32'h203);
    // a disabled mismatch gives neither fault nor warning
    wr(8'h2c, 32'h8);
    cyc(1);
    chk("mismatch disabled", {fault_o, warn_o}, 2'b00);
    wr(8'h2c, 32'h0);
    wr(8'h18, 32'h0);
    cyc(1);
    chk("masked irq", irq_o, 1'b0);
    wr(8'h18, 32'h3f);
    cyc(1);
    chk("unmasked irq", irq_o, 1'b1);
    mod(4, 1, 0, 0, 0, 1, 10'h201);
    mod(3, 1, 0, 0, 0, 0, 10'h201);
    cyc(4);
    rdchk("undetected", 8'h4c, 32'hffff);
    mod(3, 1, 0, 0, 0, 1, 10'h201);
    cyc(4);
    pulse_ack;
    wr(8'h14, 32'hffffffff);
  endtask
  task automatic t_fuse;
    // mask everything so only the unmaskable path can raise the interrupt
    wr(8'h18, 32'h0);
    mod(5, 1, 0, 1, 0, 1, 10'h201);
    mod(6, 1, 0, 0, 1, 1, 10'h201);
    cyc(4);
    chk("fuse irq unmasked", {fault_o, irq_o}, 2'b11);
    rdchk("fuse word", 8'h20, 32'h20);
    rdchk("heat word", 8'h24, 32'h40);
    mod(5, 1, 0, 0, 0, 1, 10'h201);
    mod(6, 1, 0, 0, 0, 1, 10'h201);
    cyc(4);
    pulse_ack;
    wr(8'h14, 32'hffffffff);
    cyc(1);
    chk("cleared", {fault_o, irq_o}, 2'b00);
  endtask
  task automatic t_led;
    int n;
    n = 0;
    dc_volts <= 16'd10;
    wr(8'h1c, 32'h1);
    cyc(4);
    rdchk("test mode", 8'h1c, 32'h3);
    chk("steady leds", {led_g[4:0], led_y[4:0], led_r[4:0]}, 15'b10101_00110_11000);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      n += int'(led_g[5] === 1'b1);
    end
    chk("blink", 32'(n > 0 && n < 8), 32'h1);
    wr(8'h1c, 32'h0);
    sw_on <= 1'b1;
    wr(8'h1c, 32'h1);
    cyc(4);
    rdchk("refused on", 8'h1c, 32'h1);
    wr(8'h1c, 32'h0);
    sw_on <= 1'b0;
    dc_volts <= 16'd50;
    wr(8'h1c, 32'h1);
    cyc(4);
    rdchk("refused dc", 8'h1c, 32'h1);
    wr(8'h1c, 32'h0);
  endtask
  task automatic t_family;
    logic [7:0] fam [4] = '{8'd59, 8'd60, 8'd74, 8'd75};
    logic ok [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      family <= fam[i];
      cyc(3);
      chk("fieldbus source", src_ok, ok[i]);
    end
  endtask
  initial begin
    cyc(3);
    rst_n_i <= 1'b1;
    t_reset;
    t_regs;
    t_link;
    t_size;
    t_fuse;
    t_led;
    t_family;
    end_sim;
  end
endmodule
`default_nettype wire
